// ---- rtl/clcr_defines.svh ----
// offsets, field positions, reset values and timing counts of the charge limit registers
`ifndef CLCR_DEFINES_SVH
`define CLCR_DEFINES_SVH

`define CLCR_OFF_FAST_CHARGE_CURRENT    8'h04
`define CLCR_OFF_PRECHARGE_TERM_CURRENT 8'h05
`define CLCR_OFF_CHARGE_VOLTAGE_LIMIT   8'h06
`define CLCR_OFF_CHARGER_CONTROL_TWO    8'h07

`define CLCR_RST_FAST_CHARGE_CURRENT    8'h20
`define CLCR_RST_PRECHARGE_TERM_CURRENT 8'h13
`define CLCR_RST_CHARGE_VOLTAGE_LIMIT   8'h5A
`define CLCR_RST_CHARGER_CONTROL_TWO    8'h9D

`define CLCR_FAST_CODE_MAX              7'h4F
`define CLCR_VOLT_CODE_MAX              6'h30

`define CLCR_BIT_PULSE_EN               7
`define CLCR_BIT_TERM_EN                7
`define CLCR_BIT_RESERVED               6
`define CLCR_BIT_TIMER_EN               3
`define CLCR_BIT_COLD_SCALE             0
`define CLCR_BIT_PRECHG_THRESH          1
`define CLCR_BIT_RECHG_OFFSET           0

`define CLCR_CLOCK_HZ                   64'd50000000
`define CLCR_WD_BASE_SEC                64'd40
`define CLCR_WD_BASE_CYCLES             (`CLCR_WD_BASE_SEC * `CLCR_CLOCK_HZ)

`endif

// ---- rtl/clcr_pkg.sv ----
// types shared by the charge limit register block
package clcr_pkg;
    typedef enum logic [3:0] {
        clcr_idle,
        clcr_addr,
        clcr_addr_ack,
        clcr_ptr,
        clcr_ptr_ack,
        clcr_wdata,
        clcr_wdata_ack,
        clcr_rdata,
        clcr_rdata_ack
    } clcr_state_type;
endpackage

// ---- rtl/clcr_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module clcr_sync #(
    parameter int        WIDTH    = 1,
    parameter logic      IDLE_VAL = 1'b1
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    initial begin
        if (WIDTH < 1) begin
            $error("clcr_sync: WIDTH must be at least 1");
        end
    end

    // idle value matches a released open-drain bus
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q   <= {WIDTH{IDLE_VAL}};
            sync_out <= {WIDTH{IDLE_VAL}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ---- rtl/clcr_top.sv ----
// charge limit configuration registers behind a two-wire serial slave
//
// Contract
// R1: charge current bit 7 enables current pulse control; default clear.
// R2: fast-charge current is seven-bit code, 64 mA per step, default 0x20.
// R3: fast-charge code of zero means charging is disabled.
// R4: fast-charge code written above 0x4F is stored as 0x4F.
// R5: pre-charge current four-bit code, 64 plus 64n mA, default 0001.
// R6: termination current four-bit code, 64 plus 64n mA, default 0011.
// R7: charge voltage six-bit code, offset set by range select, default 0x16.
// R8: charge voltage code written above 0x30 is stored as 0x30.
// R9: pre-charge threshold bit selects 2.8 V or 3.0 V, default set.
// R10: recharge offset bit selects 100 mV or 200 mV below limit, default clear.
// R11: control two bit 7 enables termination; default enabled.
// R12: watchdog field: 00 off, else 40, 80 or 160 s; default 01.
// R13: safety timer enable bit, default on.
// R14: fast-charge timer field picks 5, 8, 12 or 20 h; default 10.
// R15: cold range scale bit picks 50 or 20 percent; default set.
// R16: host restarts watchdog in time; device clears restart bit on expiry.
// R17: pulse up/down settable only when enabled; cleared when sequence completes.
// R18: all fields return to defaults on register reset or watchdog expiry.
// R19: reserved control two bit 6 stored, read back, no effect, default zero.
`timescale 1ns/1ps
`include "clcr_defines.svh"
module clcr_top
    import clcr_pkg::*;
#(
    parameter logic [6:0]  SLAVE_ADDR     = 7'h3B,
    parameter logic [34:0] WD_BASE_CYCLES = 35'(`CLCR_WD_BASE_CYCLES)
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // two-wire serial pins
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // neighbouring register block, same clock
    input  wire logic       reg_reset,
    input  wire logic       watchdog_restart,
    input  wire logic       pulse_up_req,
    input  wire logic       pulse_down_req,
    input  wire logic       pulse_seq_done,
    output logic            watchdog_expired,
    // configuration to the charging loops
    output logic            pulse_ctrl_enable,
    output logic [6:0]      fast_charge_current_code,
    output logic            charge_disabled,
    output logic [3:0]      precharge_current_code,
    output logic [3:0]      termination_current_code,
    output logic [5:0]      charge_voltage_code,
    output logic            precharge_threshold_select,
    output logic            recharge_offset_select,
    output logic            termination_enable,
    output logic            reserved_bit,
    output logic [1:0]      watchdog_code,
    output logic            safety_timer_enable,
    output logic [1:0]      fast_charge_timer_code,
    output logic            cold_range_current_scale,
    output logic            pulse_volt_up,
    output logic            pulse_volt_down
);
    logic           scl_s;
    logic           sda_s;
    logic           scl_p_q;
    logic           sda_p_q;
    logic           scl_rise;
    logic           scl_fall;
    logic           start_seen;
    logic           stop_seen;
    clcr_state_type state_q;
    logic [3:0]     bit_cnt_q;
    logic [7:0]     shift_q;
    logic [7:0]     tx_q;
    logic [7:0]     ptr_q;
    logic           rw_q;
    logic           nack_q;
    logic           reg_wr_q;
    logic [7:0]     reg_wr_addr_q;
    logic [7:0]     reg_wr_data_q;
    logic [7:0]     rd_data;
    logic           defaults;
    logic [34:0]    wd_cnt_q;
    logic [34:0]    wd_period;

    initial begin
        if (WD_BASE_CYCLES < 35'd1 || WD_BASE_CYCLES > 35'h7FFFFFFFF / 35'd4) begin
            $error("clcr_top: WD_BASE_CYCLES out of range");
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    clcr_sync #(.WIDTH(2), .IDLE_VAL(1'b1)) u_pin_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in ({scl, sda_in}),
        .sync_out ({scl_s, sda_s})
    );

    always_ff @(posedge clock) begin
        if (rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    assign scl_rise   = scl_s && !scl_p_q;
    assign scl_fall   = !scl_s && scl_p_q;
    assign start_seen = scl_s && scl_p_q && sda_p_q && !sda_s;
    assign stop_seen  = scl_s && scl_p_q && !sda_p_q && sda_s;

    // open drain: the line is only ever pulled low
    always_ff @(posedge clock) begin
        sda_out <= 1'b0;
    end

    // serial slave: sample on rising clock, change data on falling clock
    always_ff @(posedge clock) begin
        reg_wr_q <= 1'b0;
        if (rst) begin
            state_q       <= clcr_idle;
            bit_cnt_q     <= 4'h0;
            shift_q       <= 8'h00;
            tx_q          <= 8'h00;
            ptr_q         <= 8'h00;
            rw_q          <= 1'b0;
            nack_q        <= 1'b0;
            sda_oe        <= 1'b0;
            reg_wr_addr_q <= 8'h00;
            reg_wr_data_q <= 8'h00;
        end else if (start_seen) begin
            state_q   <= clcr_addr;
            bit_cnt_q <= 4'h0;
            sda_oe    <= 1'b0;
        end else if (stop_seen) begin
            state_q <= clcr_idle;
            sda_oe  <= 1'b0;
        end else if (scl_rise) begin
            if (state_q inside {clcr_addr, clcr_ptr, clcr_wdata, clcr_rdata}) begin
                shift_q   <= {shift_q[6:0], sda_s};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (state_q == clcr_rdata_ack) begin
                nack_q <= sda_s;
                ptr_q  <= ptr_q + 8'h01;
            end
        end else if (scl_fall) begin
            unique case (state_q)
                clcr_idle, clcr_ptr_ack: begin
                    sda_oe    <= 1'b0;
                    bit_cnt_q <= 4'h0;
                    if (state_q == clcr_ptr_ack) begin
                        state_q <= clcr_wdata;
                    end
                end
                clcr_addr: begin
                    if (bit_cnt_q == 4'h8) begin
                        bit_cnt_q <= 4'h0;
                        if (shift_q[7:1] == SLAVE_ADDR) begin
                            rw_q    <= shift_q[0];
                            sda_oe  <= 1'b1;
                            state_q <= clcr_addr_ack;
                        end else begin
                            state_q <= clcr_idle;
                        end
                    end
                end
                clcr_addr_ack: begin
                    bit_cnt_q <= 4'h0;
                    if (rw_q) begin
                        tx_q    <= rd_data;
                        sda_oe  <= !rd_data[7];
                        state_q <= clcr_rdata;
                    end else begin
                        sda_oe  <= 1'b0;
                        state_q <= clcr_ptr;
                    end
                end
                clcr_ptr: begin
                    if (bit_cnt_q == 4'h8) begin
                        bit_cnt_q <= 4'h0;
                        ptr_q     <= shift_q;
                        sda_oe    <= 1'b1;
                        state_q   <= clcr_ptr_ack;
                    end
                end
                clcr_wdata: begin
                    if (bit_cnt_q == 4'h8) begin
                        bit_cnt_q     <= 4'h0;
                        reg_wr_q      <= 1'b1;
                        reg_wr_addr_q <= ptr_q;
                        reg_wr_data_q <= shift_q;
                        sda_oe        <= 1'b1;
                        state_q       <= clcr_wdata_ack;
                    end
                end
                clcr_wdata_ack: begin
                    sda_oe  <= 1'b0;
                    ptr_q   <= ptr_q + 8'h01;
                    state_q <= clcr_wdata;
                end
                clcr_rdata: begin
                    if (bit_cnt_q == 4'h8) begin
                        bit_cnt_q <= 4'h0;
                        sda_oe    <= 1'b0;
                        state_q   <= clcr_rdata_ack;
                    end else begin
                        tx_q   <= {tx_q[6:0], 1'b1};
                        sda_oe <= !tx_q[6];
                    end
                end
                clcr_rdata_ack: begin
                    bit_cnt_q <= 4'h0;
                    if (nack_q) begin
                        state_q <= clcr_idle;
                    end else begin
                        tx_q    <= rd_data;
                        sda_oe  <= !rd_data[7];
                        state_q <= clcr_rdata;
                    end
                end
            endcase
        end
    end

    // unmapped offsets read as zero and swallow writes, still acknowledged
    always_comb begin
        rd_data = 8'h00;
        case (ptr_q)
            `CLCR_OFF_FAST_CHARGE_CURRENT:
                rd_data = {pulse_ctrl_enable, fast_charge_current_code};
            `CLCR_OFF_PRECHARGE_TERM_CURRENT:
                rd_data = {precharge_current_code, termination_current_code};
            `CLCR_OFF_CHARGE_VOLTAGE_LIMIT:
                rd_data = {charge_voltage_code, precharge_threshold_select,
                           recharge_offset_select};
            `CLCR_OFF_CHARGER_CONTROL_TWO:
                rd_data = {termination_enable, reserved_bit, watchdog_code,
                           safety_timer_enable, fast_charge_timer_code,
                           cold_range_current_scale};
            default:
                rd_data = 8'h00;
        endcase
    end

    assign defaults = reg_reset || watchdog_expired; // [R18]

    // configuration fields; defaults take priority over a same-cycle write
    always_ff @(posedge clock) begin
        if (rst || defaults) begin
            {pulse_ctrl_enable, fast_charge_current_code} <= `CLCR_RST_FAST_CHARGE_CURRENT; // [R1] [R2]
            {precharge_current_code, termination_current_code} <=
                `CLCR_RST_PRECHARGE_TERM_CURRENT; // [R5] [R6]
            {charge_voltage_code, precharge_threshold_select, recharge_offset_select} <=
                `CLCR_RST_CHARGE_VOLTAGE_LIMIT; // [R7] [R9] [R10]
            {termination_enable, reserved_bit, watchdog_code, safety_timer_enable,
             fast_charge_timer_code, cold_range_current_scale} <=
                `CLCR_RST_CHARGER_CONTROL_TWO; // [R11] [R12] [R13] [R14] [R15] [R19]
        end else if (reg_wr_q) begin
            case (reg_wr_addr_q)
                `CLCR_OFF_FAST_CHARGE_CURRENT: begin
                    pulse_ctrl_enable <= reg_wr_data_q[`CLCR_BIT_PULSE_EN]; // [R1]
                    fast_charge_current_code <=
                        (reg_wr_data_q[6:0] > `CLCR_FAST_CODE_MAX) ?
                        `CLCR_FAST_CODE_MAX : reg_wr_data_q[6:0]; // [R2] [R4]
                end
                `CLCR_OFF_PRECHARGE_TERM_CURRENT: begin
                    precharge_current_code   <= reg_wr_data_q[7:4]; // [R5]
                    termination_current_code <= reg_wr_data_q[3:0]; // [R6]
                end
                `CLCR_OFF_CHARGE_VOLTAGE_LIMIT: begin
                    charge_voltage_code <=
                        (reg_wr_data_q[7:2] > `CLCR_VOLT_CODE_MAX) ?
                        `CLCR_VOLT_CODE_MAX : reg_wr_data_q[7:2]; // [R7] [R8]
                    precharge_threshold_select <= reg_wr_data_q[`CLCR_BIT_PRECHG_THRESH]; // [R9]
                    recharge_offset_select     <= reg_wr_data_q[`CLCR_BIT_RECHG_OFFSET]; // [R10]
                end
                `CLCR_OFF_CHARGER_CONTROL_TWO: begin
                    termination_enable       <= reg_wr_data_q[`CLCR_BIT_TERM_EN]; // [R11]
                    reserved_bit             <= reg_wr_data_q[`CLCR_BIT_RESERVED]; // [R19]
                    watchdog_code            <= reg_wr_data_q[5:4]; // [R12]
                    safety_timer_enable      <= reg_wr_data_q[`CLCR_BIT_TIMER_EN]; // [R13]
                    fast_charge_timer_code   <= reg_wr_data_q[2:1]; // [R14]
                    cold_range_current_scale <= reg_wr_data_q[`CLCR_BIT_COLD_SCALE]; // [R15]
                end
                default: begin
                end
            endcase
        end
    end

    // one-cycle lag keeps this output straight from a flop
    always_ff @(posedge clock) begin
        if (rst) begin
            charge_disabled <= 1'b0;
        end else begin
            charge_disabled <= (fast_charge_current_code == 7'h00); // [R3]
        end
    end

    // pulse requests; a new request wins over completion in the same cycle
    always_ff @(posedge clock) begin
        if (rst || defaults) begin
            pulse_volt_up   <= 1'b0;
            pulse_volt_down <= 1'b0;
        end else begin
            if (pulse_up_req && pulse_ctrl_enable) begin
                pulse_volt_up <= 1'b1; // [R17]
            end else if (pulse_seq_done) begin
                pulse_volt_up <= 1'b0; // [R17]
            end
            if (pulse_down_req && pulse_ctrl_enable) begin
                pulse_volt_down <= 1'b1; // [R17]
            end else if (pulse_seq_done) begin
                pulse_volt_down <= 1'b0; // [R17]
            end
        end
    end

    always_comb begin
        unique case (watchdog_code)
            2'b01:   wd_period = WD_BASE_CYCLES;
            2'b10:   wd_period = WD_BASE_CYCLES << 1;
            2'b11:   wd_period = WD_BASE_CYCLES << 2;
            default: wd_period = WD_BASE_CYCLES;
        endcase
    end

    // counter restarts on every host restart; expiry needs a slow host or a watchdog_code change that cuts the period below the count
    always_ff @(posedge clock) begin
        if (rst || watchdog_restart || watchdog_code == 2'b00 || watchdog_expired) begin
            wd_cnt_q         <= 35'd0; // [R12] [R16]
            watchdog_expired <= 1'b0;
        end else if (wd_cnt_q >= wd_period - 35'd1) begin
            wd_cnt_q         <= 35'd0;
            watchdog_expired <= 1'b1; // [R12] [R16]
        end else begin
            wd_cnt_q         <= wd_cnt_q + 35'd1;
            watchdog_expired <= 1'b0;
        end
    end

    a_fast_clamp: assert property ( // [R4]
        reg_wr_q && reg_wr_addr_q == `CLCR_OFF_FAST_CHARGE_CURRENT && !defaults &&
        reg_wr_data_q[6:0] > `CLCR_FAST_CODE_MAX |=> fast_charge_current_code == 7'h4F)
        else $error("fast charge code not clamped");

    a_volt_clamp: assert property ( // [R8]
        reg_wr_q && reg_wr_addr_q == `CLCR_OFF_CHARGE_VOLTAGE_LIMIT && !defaults &&
        reg_wr_data_q[7:2] > `CLCR_VOLT_CODE_MAX |=> charge_voltage_code == 6'h30)
        else $error("charge voltage code not clamped");

    a_charge_off: assert property ( // [R3]
        fast_charge_current_code == 7'h00 |=> charge_disabled)
        else $error("zero current code did not disable charging");

    a_pulse_gate: assert property ( // [R17]
        !pulse_ctrl_enable && !pulse_volt_up |=> !pulse_volt_up)
        else $error("pulse up set while pulse control disabled");

    a_pulse_done: assert property ( // [R17]
        pulse_volt_down && pulse_seq_done && !pulse_down_req |=> !pulse_volt_down)
        else $error("pulse down not cleared at sequence end");

    a_wd_defaults: assert property ( // [R18]
        watchdog_expired |=> termination_enable && fast_charge_current_code == 7'h20 &&
        watchdog_code == 2'b01 && !reserved_bit && !pulse_ctrl_enable)
        else $error("fields not at defaults after watchdog expiry");

    a_wd_disabled: assert property ( // [R12]
        watchdog_code == 2'b00 |=> !watchdog_expired)
        else $error("watchdog expired while disabled");

    a_reserved_store: assert property ( // [R19]
        reg_wr_q && reg_wr_addr_q == `CLCR_OFF_CHARGER_CONTROL_TWO && !defaults
        |=> reserved_bit == $past(reg_wr_data_q[6]) &&
            termination_enable == $past(reg_wr_data_q[7]))
        else $error("control two bits not stored as written");
endmodule

// ---- verif/clcr_host.sv ----
// two-wire bus master model standing in for the host processor
`timescale 1ns/1ps
module clcr_host #(
    parameter logic [6:0] ADDR = 7'h3B
) (
    // clock
    input  wire logic clock,
    // bus wires
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    // data moves two cycles after scl falls so the synchroniser never sees a false start
    task automatic bit_io(input logic pull, output logic got);
        wt(2);
        sda_pull = pull;
        wt(6);
        scl = 1'b1;
        wt(4);
        got = sda;
        wt(4);
        scl = 1'b0;
    endtask
    task automatic start();
        wt(2);
        sda_pull = 1'b0;
        wt(6);
        scl = 1'b1;
        wt(8);
        sda_pull = 1'b1;
        wt(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        wt(2);
        sda_pull = 1'b1;
        wt(6);
        scl = 1'b1;
        wt(8);
        sda_pull = 1'b0;
        wt(8);
    endtask
    // tx of all ones leaves the line released so the device can drive it
    task automatic xfer(input logic [7:0] tx, input logic hack, output logic [7:0] rx,
                        output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(!tx[i], rx[i]);
        end
        bit_io(hack, s);
        ack = (s === 1'b0);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d,
                      output logic ok);
        logic [7:0] r;
        logic       k1, k2, k3;
        start();
        xfer({a, 1'b0}, 1'b0, r, k1);
        xfer(off, 1'b0, r, k2);
        xfer(d, 1'b0, r, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask
    // single byte read ends with a nack, as a real host would
    task automatic rd(input logic [7:0] off, output logic [7:0] d);
        logic [7:0] r;
        logic       k;
        start();
        xfer({ADDR, 1'b0}, 1'b0, r, k);
        xfer(off, 1'b0, r, k);
        start();
        xfer({ADDR, 1'b1}, 1'b0, r, k);
        xfer(8'hFF, 1'b0, d, k);
        stop();
    endtask
endmodule

// ---- verif/clcr_top_test.sv ----
// self-checking bench for the charge limit configuration registers
`timescale 1ns/1ps
module clcr_top_test;
    typedef struct packed {logic [7:0] off; logic [7:0] wr; logic [7:0] exp;} clcr_row_type;
    localparam logic [6:0] ADDR = 7'h3B;
    // shortened watchdog base so three periods fit in the run
    localparam int         WD   = 3000;
    logic       clock, rst, reg_reset, watchdog_restart, pulse_up_req, pulse_down_req;
    logic       pulse_seq_done, sda_out, sda_oe, watchdog_expired, pulse_ctrl_enable;
    logic       charge_disabled, precharge_threshold_select, recharge_offset_select;
    logic       termination_enable, reserved_bit, safety_timer_enable, cold_range_current_scale;
    logic       pulse_volt_up, pulse_volt_down, scl, host_pull, ok;
    logic [6:0] fast_charge_current_code;
    logic [3:0] precharge_current_code, termination_current_code;
    logic [5:0] charge_voltage_code;
    logic [1:0] watchdog_code, fast_charge_timer_code;
    logic [7:0] got;
    wire logic  sda_line = !(host_pull | sda_oe);
    // all four registers as the bench sees them, 0x04 in the top byte
    wire logic [31:0] regs_seen = {pulse_ctrl_enable, fast_charge_current_code,
        precharge_current_code, termination_current_code, charge_voltage_code,
        precharge_threshold_select, recharge_offset_select, termination_enable, reserved_bit,
        watchdog_code, safety_timer_enable, fast_charge_timer_code, cold_range_current_scale};
    int         n_fail, checks_done, n;
    logic [7:0] dflt [4] = '{8'h20, 8'h13, 8'h5A, 8'h9D};
    clcr_row_type rows [11] = '{'{8'h07, 8'h4E, 8'h4E}, '{8'h07, 8'h88, 8'h88},
        '{8'h07, 8'h03, 8'h03}, '{8'h04, 8'hCF, 8'hCF}, '{8'h04, 8'h7F, 8'h4F},
        '{8'h04, 8'h50, 8'h4F}, '{8'h04, 8'h00, 8'h00}, '{8'h05, 8'hA5, 8'hA5},
        '{8'h06, 8'hC3, 8'hC3}, '{8'h06, 8'hC6, 8'hC2}, '{8'h06, 8'hFD, 8'hC1}};

    clcr_top #(.SLAVE_ADDR(ADDR), .WD_BASE_CYCLES(35'(WD))) dut_u (
        .clock(clock), .rst(rst), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .reg_reset(reg_reset), .watchdog_restart(watchdog_restart),
        .pulse_up_req(pulse_up_req), .pulse_down_req(pulse_down_req),
        .pulse_seq_done(pulse_seq_done), .watchdog_expired(watchdog_expired),
        .pulse_ctrl_enable(pulse_ctrl_enable),
        .fast_charge_current_code(fast_charge_current_code),
        .charge_disabled(charge_disabled), .precharge_current_code(precharge_current_code),
        .termination_current_code(termination_current_code),
        .charge_voltage_code(charge_voltage_code),
        .precharge_threshold_select(precharge_threshold_select),
        .recharge_offset_select(recharge_offset_select),
        .termination_enable(termination_enable), .reserved_bit(reserved_bit),
        .watchdog_code(watchdog_code), .safety_timer_enable(safety_timer_enable),
        .fast_charge_timer_code(fast_charge_timer_code),
        .cold_range_current_scale(cold_range_current_scale),
        .pulse_volt_up(pulse_volt_up), .pulse_volt_down(pulse_volt_down));
    clcr_host #(.ADDR(ADDR)) host_u (.clock(clock), .sda(sda_line), .scl(scl),
        .sda_pull(host_pull));

    always #10 clock = ~clock;

    function automatic logic [7:0] view(input logic [7:0] off);
        case (off)
            8'h04: return regs_seen[31:24];
            8'h05: return regs_seen[23:16];
            8'h06: return regs_seen[15:8];
            default: return regs_seen[7:0];
        endcase
    endfunction
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t value %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask
    task automatic chk_dflt();
        for (int k = 0; k < 4; k++) begin
            chk8(view(8'(8'h04 + k)), dflt[k]);
        end
    endtask
    task automatic end_sim();
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #2000000;
        n_fail++;
        end_sim();
    end

    initial begin
        clock = 0;
        rst = 1;
        reg_reset = 0;
        watchdog_restart = 0;
        pulse_up_req = 0;
        pulse_down_req = 0;
        pulse_seq_done = 0;
        host_u.wt(4);
        rst = 0;
        host_u.wt(3);
        chk_dflt();
        chk1(pulse_ctrl_enable | charge_disabled | sda_oe | sda_out | pulse_volt_up, 1'b0);
        foreach (rows[i]) begin
            host_u.wr(ADDR, rows[i].off, rows[i].wr, ok);
            chk1(ok, 1'b1);
            host_u.rd(rows[i].off, got);
            chk8(got, rows[i].exp);
            chk8(view(rows[i].off), rows[i].exp);
            if (rows[i].off == 8'h04)
                chk1(charge_disabled, rows[i].exp[6:0] == 7'h00);
        end
        // unmapped offset reads as zero, a foreign address is not acknowledged
        host_u.rd(8'h10, got);
        chk8(got, 8'h00);
        host_u.wr(ADDR ^ 7'h01, 8'h04, 8'h33, ok);
        chk1(ok, 1'b0);
        chk8(view(8'h04), 8'h00);
        pulse_up_req = 1;
        host_u.wt(1);
        pulse_up_req = 0;
        host_u.wt(1);
        chk1(pulse_volt_up, 1'b0);
        host_u.wr(ADDR, 8'h04, 8'hA0, ok);
        pulse_up_req = 1;
        pulse_down_req = 1;
        host_u.wt(1);
        pulse_down_req = 0;
        pulse_seq_done = 1;
        host_u.wt(1);
        pulse_up_req = 0;
        pulse_seq_done = 0;
        host_u.wt(1);
        chk1(pulse_volt_up, 1'b1);
        chk1(pulse_volt_down, 1'b0);
        reg_reset = 1;
        host_u.wt(1);
        reg_reset = 0;
        host_u.wt(1);
        chk_dflt();
        chk1(pulse_volt_up, 1'b0);
        for (int c = 1; c < 4; c++) begin
            host_u.wr(ADDR, 8'h04, 8'h05, ok);
            host_u.wr(ADDR, 8'h07, 8'(8'h8D | (c << 4)), ok);
            watchdog_restart = 1;
            host_u.wt(1);
            watchdog_restart = 0;
            n = 1;
            while (watchdog_expired !== 1'b1 && n < 20000) begin
                host_u.wt(1);
                n++;
            end
            chk1(n >= WD * (1 << (c - 1)) - 3 && n <= WD * (1 << (c - 1)) + 3, 1'b1);
            host_u.wt(1);
            chk1(watchdog_expired, 1'b0);
            host_u.wt(1);
            chk_dflt();
        end
        // reset in mid-run must bring back the defaults over a written value
        host_u.wr(ADDR, 8'h05, 8'h00, ok);
        chk1(ok, 1'b1);
        rst = 1;
        host_u.wt(4);
        rst = 0;
        host_u.wt(3);
        chk_dflt();
        chk1(sda_oe | watchdog_expired | pulse_volt_down | charge_disabled, 1'b0);
        end_sim();
    end
endmodule
